// >>> mcf_pkg.sv
/*
  Package for the motion common flag block: widths, reset values,
  command and status carriers.
  Assumes one 100 MHz clock and an active-low asynchronous reset.
*/
package mcf_pkg;

  // ************************************************************
  // Sizes and reset values
  // ************************************************************
  localparam int          MCF_AXES           = 32;
  localparam int          MCF_PULSE_GENS     = 3;
  localparam int          MCF_HIST_WORDS     = 96;
  localparam int          MCF_HIST_AW        = 7;
  localparam logic [7:0]  MCF_SEG_NORMAL     = 8'h00;
  localparam logic [7:0]  MCF_SEG_SYS_ERROR  = 8'h5e;
  localparam logic [31:0] MCF_AXES_RESET     = 32'h0000_0000;
  localparam logic [2:0]  MCF_PG_RESET       = 3'h0;
  localparam int          MCF_CLK_MHZ        = 100;
  localparam int          MCF_CYCLE_US       = 1;
  localparam int          MCF_CYCLE_CLKS     = MCF_CYCLE_US * MCF_CLK_MHZ;
  localparam logic [15:0] MCF_CYCLE_RESET    = 16'h0000;

  // ************************************************************
  // Carriers
  // ************************************************************
  // Start, stop and speed change events per axis from the motion engine.
  typedef struct packed {
    logic [31:0] start_req;
    logic [31:0] pos_complete;
    logic [31:0] stop_midway;
    logic [31:0] stop_by_zero_speed;
    logic [31:0] speed_change_begin;
  } mcf_axis_ev_s;

  // Per-axis results driven to the motion engine.
  typedef struct packed {
    logic [31:0] start_granted;
    logic [31:0] start_accept_on_error;
    logic [31:0] servo_enable;
    logic [31:0] jog_start;
    logic [31:0] decel_stop;
  } mcf_axis_ctl_s;

  typedef enum logic [2:0] {
    MCF_HC_IDLE  = 3'b001,
    MCF_HC_ERASE = 3'b010,
    MCF_HC_DONE  = 3'b100
  } mcf_hclr_e;

endpackage

// >>> mcf_edge.sv
/*
  Rising and falling edge detector for a bus of command flags.
  Assumes inputs are already in the core clock domain.
*/
`timescale 1ns/1ns
module mcf_edge
  import mcf_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  // Flags
  input  wire logic [W-1:0] level_in,
  output logic      [W-1:0] rise_out,
  output logic      [W-1:0] fall_out
);

  logic [W-1:0] prev;
  logic [W-1:0] next_prev;

  // Previous value follows the level.
  always_comb
  begin
    next_prev = level_in;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prev <= '0;
    end
    else
    begin
      prev <= next_prev;
    end
  end

  // Edges are combinational from the registered history.
  assign rise_out = level_in & ~prev;
  assign fall_out = ~level_in & prev;

endmodule

// >>> mcf_flags.sv
/*
  Common command and status flags of a multi-axis motion controller.
  Assumes the host, the motion engine and the slot monitor all run on
  core_clk_in, except the pulse generator pins, which are synchronised.
*/
// Behaviour
// R01 - Host software must never force start accept flags; forcing breaks positioning.
// R02 - Start accept flag forced on while idle refuses the next start with error.
// R03 - Error history clear rising edge erases history, then clears the request.
// R04 - Speed switch option set before start applies speed from first pass point.
// R05 - System setting error flag set refuses every positioning start until reset.
// R06 - System setting error drives flag high and shows code on seven-segment.
// R07 - Servo enabled only with servo on, no axis off, no error, no forced stop.
// R08 - All-axes servo on stays set through STOP; forced stop clears it.
// R09 - Host changes servo on only after positioning; changes while moving are ignored.
// R10 - Slot fault flag follows module checks continuously from power-up.
// R11 - Slot fault refuses starts; any flag change decelerates moving axes.
// R12 - JOG simultaneous start command starts JOG on every selected axis.
// R13 - Clearing JOG simultaneous start decelerates every axis it started.
// R14 - Servo on accept flag set on acceptance without checking servo ready.
// R15 - Each pulse generator drives positioning only while enabled; enables reset off.
// R16 - Cycle overrun flag sets on overrun and holds until reset or user clear.
// R17 - Speed change accepting flag per axis sets when speed change begins.
// R18 - Start accept sets on start, clears on completion or midway non-zero stop.
// R19 - Reset clears all status; command flags are detected by edges. Here only clear request and JOG are edge-detected; the others are levels.
`timescale 1ns/1ns
module mcf_flags
  import mcf_pkg::*;
#(
  parameter int AXES = MCF_AXES
)
(
  // Clock and reset
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_n_in,
  // Host command flags
  input  wire logic                      error_history_clear_request_in,
  input  wire logic                      speed_switch_point_option_in,
  input  wire logic                      all_axes_servo_on_cmd_in,
  input  wire logic                      jog_simultaneous_start_cmd_in,
  input  wire logic [MCF_PULSE_GENS-1:0] pulse_generator_enable_in,
  input  wire logic                      cycle_overrun_clear_in,
  input  wire logic [31:0]               jog_group_axis_select_in,
  input  wire logic [31:0]               axis_servo_off_cmd_in,
  input  wire logic [31:0]               axis_servo_error_in,
  input  wire logic [31:0]               axis_start_accept_force_in,
  // System conditions
  input  wire logic                      system_setting_fault_in,
  input  wire logic                      slot_module_abnormal_in,
  input  wire logic                      forced_stop_in,
  input  wire logic                      cycle_tick_in,
  input  wire logic [15:0]               operation_cycle_setting_in,
  input  wire logic                      motion_busy_in,
  input  wire logic [MCF_PULSE_GENS-1:0] pulse_gen_pin_in,
  // Motion engine events
  input  wire mcf_axis_ev_s              axis_ev_in,
  input  wire logic                      const_speed_start_in,
  // Status flags
  output logic [31:0]                    start_accept_flag_out,
  output logic [31:0]                    speed_change_accepting_flag_out,
  output logic                           system_setting_error_flag_out,
  output logic                           slot_fault_flag_out,
  output logic                           servo_on_accept_flag_out,
  output logic                           cycle_overrun_flag_out,
  output logic                           error_history_clear_request_out,
  output logic [7:0]                     seven_seg_code_out,
  // Engine controls
  output mcf_axis_ctl_s                  axis_ctl_out,
  output logic                           speed_from_first_point_out,
  output logic [MCF_PULSE_GENS-1:0]      pulse_gen_step_out,
  output logic                           hist_we_out,
  output logic [MCF_HIST_AW-1:0]         hist_addr_out
);

  // ************************************************************
  // Command edge detection
  // ************************************************************
  logic [1:0] cmd_rise;
  logic [1:0] cmd_fall;

  // Clear request and JOG command are edge triggered.
  mcf_edge #(.W(2)) u_edge (                                      // R19
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .level_in    ({jog_simultaneous_start_cmd_in, error_history_clear_request_in}),
    .rise_out    (cmd_rise),
    .fall_out    (cmd_fall)
  );

  // ************************************************************
  // Pulse generator pin synchroniser
  // ************************************************************
  logic [MCF_PULSE_GENS-1:0] pg_s1, pg_s2, pg_s3;

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pg_s1 <= MCF_PG_RESET;
      pg_s2 <= MCF_PG_RESET;
      pg_s3 <= MCF_PG_RESET;
    end
    else
    begin
      pg_s1 <= pulse_gen_pin_in;
      pg_s2 <= pg_s1;
      pg_s3 <= pg_s2;
    end
  end

  // ************************************************************
  // Flag state
  // ************************************************************
  logic [31:0]               start_acc, next_start_acc;
  logic [31:0]               spd_acc, next_spd_acc;
  logic [31:0]               jog_owned, next_jog_owned;
  logic                      sys_err, next_sys_err;
  logic                      slot_f, next_slot_f;
  logic                      servo_on, next_servo_on;
  logic                      servo_acc, next_servo_acc;
  logic                      ovr, next_ovr;
  logic                      first_pt, next_first_pt;
  logic [15:0]               cyc_cnt, next_cyc_cnt;
  mcf_axis_ctl_s             ctl, next_ctl;
  logic [MCF_PULSE_GENS-1:0] pg_step, next_pg_step;
  logic [7:0]                seg, next_seg;
  logic [31:0]               refuse;

  // Next values of the status flags and the engine controls, except the history erase request, write enable and address.
  always_comb
  begin
    refuse          = {32{sys_err | slot_f}};                     // R05 R11
    next_sys_err    = sys_err | system_setting_fault_in;          // R05 R06
    next_slot_f     = slot_module_abnormal_in;                    // R10
    next_seg        = next_sys_err ? MCF_SEG_SYS_ERROR : MCF_SEG_NORMAL; // R06
    next_ctl        = '0;
    // A forced-on flag while idle makes the next start fail.
    next_ctl.start_accept_on_error = axis_ev_in.start_req & ~refuse
                                     & axis_start_accept_force_in;   // R02
    next_ctl.start_granted = axis_ev_in.start_req & ~refuse
                             & ~axis_start_accept_force_in & ~start_acc;
    next_start_acc  = (start_acc & ~(axis_ev_in.pos_complete
                      | (axis_ev_in.stop_midway & ~axis_ev_in.stop_by_zero_speed)))
                      | next_ctl.start_granted;                   // R18
    // Speed change flag drops together with its start accept flag.
    next_spd_acc    = (spd_acc | (axis_ev_in.speed_change_begin & start_acc))
                      & next_start_acc;                           // R17
    // Servo on only changes while no positioning is under way, except that a forced stop clears it at any time.
    next_servo_on   = servo_on;
    if (!motion_busy_in)
      next_servo_on = all_axes_servo_on_cmd_in;                   // R09
    if (forced_stop_in)
      next_servo_on = 1'b0;                                       // R08
    next_servo_acc  = next_servo_on;                              // R14
    next_ctl.servo_enable = {32{servo_on & ~forced_stop_in}}
                            & ~axis_servo_off_cmd_in & ~axis_servo_error_in; // R07
    // JOG group start and stop.
    next_jog_owned  = jog_owned;
    if (cmd_rise[1] && !(sys_err || slot_f))
    begin
      next_ctl.jog_start = jog_group_axis_select_in;              // R12
      next_jog_owned     = jog_group_axis_select_in;
    end
    if (cmd_fall[1])
    begin
      next_ctl.decel_stop = jog_owned;                            // R13
      next_jog_owned      = '0;
    end
    if (next_slot_f != slot_f)
      next_ctl.decel_stop = next_ctl.decel_stop | start_acc;      // R11
    // Option latched at constant speed start.
    next_first_pt   = first_pt;
    if (const_speed_start_in)
      next_first_pt = speed_switch_point_option_in;               // R04
    next_pg_step    = (pg_s2 & ~pg_s3) & pulse_generator_enable_in; // R15
    // Operation cycle watchdog.
    next_cyc_cnt    = (motion_busy_in && !cycle_tick_in) ? cyc_cnt + 16'h0001 : '0;
    // A new overrun wins over a clear in the same cycle.
    next_ovr        = ovr;
    if (cycle_overrun_clear_in)
      next_ovr = 1'b0;
    if (motion_busy_in && cyc_cnt > operation_cycle_setting_in)
      next_ovr = 1'b1;                                            // R16
  end

  // Registers of the flag state.
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)                                                // R19
    begin
      start_acc <= MCF_AXES_RESET;
      spd_acc   <= MCF_AXES_RESET;
      jog_owned <= MCF_AXES_RESET;
      sys_err   <= 1'b0;
      slot_f    <= 1'b0;
      servo_on  <= 1'b0;
      servo_acc <= 1'b0;
      ovr       <= 1'b0;
      first_pt  <= 1'b0;
      cyc_cnt   <= MCF_CYCLE_RESET;
      ctl       <= '0;
      pg_step   <= MCF_PG_RESET;
      seg       <= MCF_SEG_NORMAL;
    end
    else
    begin
      start_acc <= next_start_acc;
      spd_acc   <= next_spd_acc;
      jog_owned <= next_jog_owned;
      sys_err   <= next_sys_err;
      slot_f    <= next_slot_f;
      servo_on  <= next_servo_on;
      servo_acc <= next_servo_acc;
      ovr       <= next_ovr;
      first_pt  <= next_first_pt;
      cyc_cnt   <= next_cyc_cnt;
      ctl       <= next_ctl;
      pg_step   <= next_pg_step;
      seg       <= next_seg;
    end
  end

  // ************************************************************
  // Error history erase sequencer
  // ************************************************************
  mcf_hclr_e            hstate, next_hstate;
  logic [MCF_HIST_AW-1:0] haddr, next_haddr;
  logic                 hreq, next_hreq;
  logic                 hwe, next_hwe;

  // Rising edge starts a walk over every history word, then drops the request.
  always_comb
  begin
    next_hstate = hstate;
    next_haddr  = haddr;
    next_hreq   = hreq;
    next_hwe    = 1'b0;
    case (hstate)
      MCF_HC_IDLE:
        if (cmd_rise[0])                                          // R03
        begin
          next_hreq   = 1'b1;
          next_haddr  = '0;
          next_hwe    = 1'b1;
          next_hstate = MCF_HC_ERASE;
        end
      MCF_HC_ERASE:
        if (haddr == MCF_HIST_AW'(MCF_HIST_WORDS - 1))
          next_hstate = MCF_HC_DONE;
        else
        begin
          next_haddr = haddr + 1'b1;
          next_hwe   = 1'b1;
        end
      MCF_HC_DONE:
      begin
        next_hreq   = 1'b0;                                       // R03
        next_hstate = MCF_HC_IDLE;
      end
      default:
        next_hstate = MCF_HC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hstate <= MCF_HC_IDLE;
      haddr  <= '0;
      hreq   <= 1'b0;
      hwe    <= 1'b0;
    end
    else
    begin
      hstate <= next_hstate;
      haddr  <= next_haddr;
      hreq   <= next_hreq;
      hwe    <= next_hwe;
    end
  end

  // ************************************************************
  // Outputs, each straight from a register
  // ************************************************************
  assign start_accept_flag_out           = start_acc;
  assign speed_change_accepting_flag_out = spd_acc;
  assign system_setting_error_flag_out   = sys_err;
  assign slot_fault_flag_out             = slot_f;
  assign servo_on_accept_flag_out        = servo_acc;
  assign cycle_overrun_flag_out          = ovr;
  assign error_history_clear_request_out = hreq;
  assign seven_seg_code_out              = seg;
  assign axis_ctl_out                    = ctl;
  assign speed_from_first_point_out      = first_pt;
  assign pulse_gen_step_out              = pg_step;
  assign hist_we_out                     = hwe;
  assign hist_addr_out                   = haddr;

endmodule

// >>> mcf_host_model.sv
/*
  Far-side model: the motion cycle timer and three hand-wheel pins.
  Assumes the block's clock and its active-low asynchronous reset.
*/
`timescale 1ns/1ns
module mcf_host_model
  import mcf_pkg::*;
(
  // Clock and reset
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_n_in,
  // Far-side stimulus
  output logic                           cycle_tick_out,
  output logic [MCF_PULSE_GENS-1:0]      pin_out
);
  logic [5:0] cnt;
  logic [5:0] next_cnt;

  // Free-running count of clocks since reset.
  always_comb
  begin
    next_cnt = cnt + 6'h01;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt <= 6'h00;
    else
      cnt <= next_cnt;
  end

  // A cycle boundary every 64 clocks; the pins toggle every 8 clocks.
  assign cycle_tick_out = (cnt == 6'h3f);
  assign pin_out        = {MCF_PULSE_GENS{cnt[3]}};
endmodule

// >>> mcf_flags_properties.sv
/*
  Checker of the common flag block, bound to its ports.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
module mcf_flags_properties
  import mcf_pkg::*;
(
  // Clock, reset and inputs
  input wire logic core_clk_in, rst_n_in, error_history_clear_request_in,
  input wire logic jog_simultaneous_start_cmd_in, forced_stop_in, slot_module_abnormal_in,
  input wire logic [MCF_PULSE_GENS-1:0] pulse_generator_enable_in,
  input wire logic [31:0] jog_group_axis_select_in, axis_servo_off_cmd_in,
  input wire logic [31:0] axis_servo_error_in, axis_start_accept_force_in,
  input wire mcf_axis_ev_s axis_ev_in,
  // Outputs of the block
  input wire logic [31:0] start_accept_flag_out, speed_change_accepting_flag_out,
  input wire logic system_setting_error_flag_out, slot_fault_flag_out,
  input wire logic error_history_clear_request_out, hist_we_out,
  input wire logic [7:0] seven_seg_code_out,
  input wire logic [MCF_HIST_AW-1:0] hist_addr_out,
  input wire logic [MCF_PULSE_GENS-1:0] pulse_gen_step_out,
  input wire mcf_axis_ctl_s axis_ctl_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // A history erase opens at address zero and closes two cycles after the last word.
  sequence s_hclr_go;
    $rose(error_history_clear_request_in) ##0 !error_history_clear_request_out;
  endsequence
  sequence s_hclr_first;
    error_history_clear_request_out && hist_we_out && hist_addr_out == 7'h00;
  endsequence
  property p_hclr_start;
    s_hclr_go |=> s_hclr_first;
  endproperty
  a_hclr_start: assert property (p_hclr_start) else $error("history erase did not open");
  property p_hclr_end;
    hist_we_out && hist_addr_out == 7'h5f |=> !hist_we_out ##1 !error_history_clear_request_out;
  endproperty
  a_hclr_end: assert property (p_hclr_end) else $error("history erase did not close");
  property p_grant;
    axis_ev_in.start_req[0] && !start_accept_flag_out[0] && !axis_start_accept_force_in[0]
      && !system_setting_error_flag_out && !slot_fault_flag_out
      |=> axis_ctl_out.start_granted[0] && start_accept_flag_out[0];
  endproperty
  a_grant: assert property (p_grant) else $error("start not accepted");
  property p_block;
    system_setting_error_flag_out || slot_fault_flag_out |=> axis_ctl_out.start_granted == 32'h0;
  endproperty
  a_block: assert property (p_block) else $error("start granted while faulted");
  property p_seg;
    system_setting_error_flag_out |-> seven_seg_code_out == MCF_SEG_SYS_ERROR;
  endproperty
  a_seg: assert property (p_seg) else $error("display code wrong");
  property p_slot;
    1'b1 |=> slot_fault_flag_out == $past(slot_module_abnormal_in);
  endproperty
  a_slot: assert property (p_slot) else $error("slot flag does not follow");
  property p_servo;
    forced_stop_in || axis_servo_off_cmd_in[0] || axis_servo_error_in[0]
      |=> !axis_ctl_out.servo_enable[0];
  endproperty
  a_servo: assert property (p_servo) else $error("servo enabled wrongly");
  property p_jog;
    $rose(jog_simultaneous_start_cmd_in) && !system_setting_error_flag_out && !slot_fault_flag_out
      |=> axis_ctl_out.jog_start == $past(jog_group_axis_select_in);
  endproperty
  a_jog: assert property (p_jog) else $error("jog group start wrong");
  property p_pg;
    !pulse_generator_enable_in[0] [*4] |-> !pulse_gen_step_out[0];
  endproperty
  a_pg: assert property (p_pg) else $error("step from disabled generator");
  property p_sca;
    axis_ev_in.speed_change_begin[0] && start_accept_flag_out[0]
      |=> speed_change_accepting_flag_out[0];
  endproperty
  a_sca: assert property (p_sca) else $error("speed change flag not set");
endmodule

bind mcf_flags mcf_flags_properties u_props (.*);

// >>> tb_mcf_flags.sv
/*
  Self-checking bench of the common flag block with the far-side model.
  Assumes the package and the checker bound to the block.
*/
`timescale 1ns/1ns
module tb_mcf_flags
  import mcf_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic rst_n_in, error_history_clear_request_in, speed_switch_point_option_in;
  logic all_axes_servo_on_cmd_in, jog_simultaneous_start_cmd_in, cycle_overrun_clear_in;
  logic system_setting_fault_in, slot_module_abnormal_in, forced_stop_in, cycle_tick_in;
  logic motion_busy_in, const_speed_start_in, hist_we_out, speed_from_first_point_out;
  logic [2:0] pulse_generator_enable_in, pulse_gen_pin_in, pulse_gen_step_out;
  logic [31:0] jog_group_axis_select_in, axis_servo_off_cmd_in, axis_servo_error_in;
  logic [31:0] axis_start_accept_force_in, start_accept_flag_out, speed_change_accepting_flag_out;
  logic [15:0] operation_cycle_setting_in;
  mcf_axis_ev_s axis_ev_in;
  mcf_axis_ctl_s axis_ctl_out;
  logic system_setting_error_flag_out, slot_fault_flag_out, servo_on_accept_flag_out;
  logic cycle_overrun_flag_out, error_history_clear_request_out;
  logic [7:0] seven_seg_code_out;
  logic [6:0] hist_addr_out;
  int err_count = 0;
  int tests_run = 0;
  int n_we = 0;
  int n_st = 0;
  int we_base = 0;
  int st_base = 0;

  mcf_flags dut (.*);
  mcf_host_model u_host (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .cycle_tick_out(cycle_tick_in), .pin_out(pulse_gen_pin_in));

  // Clock of 10 ns period.
  always #5 core_clk_in = ~core_clk_in;

  // Counts history writes and steps of the first hand-wheel.
  always @(posedge core_clk_in)
  begin
    n_we <= n_we + 32'(hist_we_out === 1'b1);
    n_st <= n_st + 32'(pulse_gen_step_out[0] === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 400 cycles.
  initial
  begin
    #20000;
    err_count++;
    final_report();
  end

  // Main sequence; inputs change at the falling edge only.
  initial
  begin
    {error_history_clear_request_in, speed_switch_point_option_in, all_axes_servo_on_cmd_in,
     jog_simultaneous_start_cmd_in, cycle_overrun_clear_in, system_setting_fault_in,
     slot_module_abnormal_in, forced_stop_in, motion_busy_in, const_speed_start_in} = '0;
    {pulse_generator_enable_in, axis_servo_error_in, axis_start_accept_force_in} = '0;
    jog_group_axis_select_in = 32'h0000_0005;
    axis_servo_off_cmd_in = 32'h0000_0004;
    operation_cycle_setting_in = 16'h0004;
    axis_ev_in = '0;
    rst_n_in = 1'b0;
    cyc(5);
    rst_n_in = 1'b1;
    chk(start_accept_flag_out | speed_change_accepting_flag_out, 32'h0);
    chk({system_setting_error_flag_out, slot_fault_flag_out, seven_seg_code_out}, 32'h0);
    axis_start_accept_force_in = 32'h0000_0002;
    axis_ev_in.start_req = 32'h0000_0003;
    cyc(1);
    chk(axis_ctl_out.start_granted, 32'h1);
    chk(axis_ctl_out.start_accept_on_error, 32'h2);
    chk(start_accept_flag_out & 32'h1, 32'h1);
    axis_ev_in = '0;
    axis_start_accept_force_in = '0;
    axis_ev_in.speed_change_begin = 32'h1;
    cyc(1);
    chk(speed_change_accepting_flag_out & 32'h1, 32'h1);
    axis_ev_in = '0;
    axis_ev_in.stop_by_zero_speed = 32'h1;
    axis_ev_in.stop_midway = 32'h1;
    cyc(2);
    chk(start_accept_flag_out & 32'h1, 32'h1);
    axis_ev_in = '0;
    axis_ev_in.pos_complete = 32'h1;
    cyc(1);
    axis_ev_in = '0;
    chk(start_accept_flag_out & 32'h1, 32'h0);
    speed_switch_point_option_in = 1'b1;
    const_speed_start_in = 1'b1;
    cyc(1);
    const_speed_start_in = 1'b0;
    chk(speed_from_first_point_out, 32'h1);
    we_base = n_we;
    error_history_clear_request_in = 1'b1;
    cyc(100);
    chk(32'(n_we - we_base), 32'd96);
    chk(error_history_clear_request_out, 32'h0);
    error_history_clear_request_in = 1'b0;
    all_axes_servo_on_cmd_in = 1'b1;
    cyc(3);
    chk(servo_on_accept_flag_out, 32'h1);
    chk(axis_ctl_out.servo_enable, 32'hffff_fffb);
    axis_servo_error_in = 32'h1;
    motion_busy_in = 1'b1;
    all_axes_servo_on_cmd_in = 1'b0;
    cyc(3);
    chk(servo_on_accept_flag_out, 32'h1);
    chk(axis_ctl_out.servo_enable, 32'hffff_fffa);
    all_axes_servo_on_cmd_in = 1'b1;
    forced_stop_in = 1'b1;
    cyc(3);
    chk(servo_on_accept_flag_out, 32'h0);
    chk(axis_ctl_out.servo_enable, 32'h0);
    forced_stop_in = 1'b0;
    jog_simultaneous_start_cmd_in = 1'b1;
    cyc(1);
    chk(axis_ctl_out.jog_start, 32'h5);
    jog_simultaneous_start_cmd_in = 1'b0;
    cyc(1);
    chk(axis_ctl_out.decel_stop, 32'h5);
    st_base = n_st;
    cyc(64);
    chk(32'(n_st - st_base), 32'h0);
    pulse_generator_enable_in = 3'h1;
    st_base = n_st;
    cyc(64);
    chk(32'(n_st != st_base), 32'h1);
    cyc(70);
    chk(cycle_overrun_flag_out, 32'h1);
    motion_busy_in = 1'b0;
    cyc(70);
    chk(cycle_overrun_flag_out, 32'h1);
    cycle_overrun_clear_in = 1'b1;
    cyc(2);
    cycle_overrun_clear_in = 1'b0;
    chk(cycle_overrun_flag_out, 32'h0);
    slot_module_abnormal_in = 1'b1;
    cyc(1);
    chk(slot_fault_flag_out, 32'h1);
    axis_ev_in.start_req = 32'h8;
    cyc(1);
    chk(axis_ctl_out.start_granted, 32'h0);
    axis_ev_in = '0;
    slot_module_abnormal_in = 1'b0;
    system_setting_fault_in = 1'b1;
    cyc(2);
    chk(slot_fault_flag_out, 32'h0);
    system_setting_fault_in = 1'b0;
    chk(system_setting_error_flag_out, 32'h1);
    chk(seven_seg_code_out, 32'(MCF_SEG_SYS_ERROR));
    axis_ev_in.start_req = 32'h10;
    cyc(1);
    chk(axis_ctl_out.start_granted, 32'h0);
    axis_ev_in = '0;
    rst_n_in = 1'b0;
    cyc(2);
    rst_n_in = 1'b1;
    cyc(1);
    chk(system_setting_error_flag_out, 32'h0);
    final_report();
  end
endmodule
